/* File: rtl/rcr_regs.sv */
// Control registers of the two linear regulators and modulation select of the two switchers
`timescale 1ns/1ps
`include "rcr_consts.svh"

module rcr_regs
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic analog_regulator_enable_pin,
  input wire logic core_switcher_light_load,
  input wire logic io_switcher_light_load,
  output logic general_regulator_en,
  output logic [11:0] general_regulator_mv,
  output logic analog_regulator_en,
  output logic [11:0] analog_regulator_mv,
  output logic [4:0] core_switcher_code,
  output logic core_switcher_pwm,
  output logic [4:0] io_switcher_code,
  output logic io_switcher_pwm
);

  localparam logic [3:0] SEQ_LAST = 4'(`RCR_SEQ_CYCLES - 1); // Last count of the power-on delay

  // How the block works
  // The bank holds four control bytes behind a plain byte port: the general
  // regulator, the analog regulator and the two switchers. The serial slave
  // in front of the port turns each host byte write into a one-cycle strobe.
  //
  // Register layout, the same for all four bytes:
  //   bits 7..6  reserved, never stored, always read back as zero
  //   bit  5     control bit: enable, override or force-PWM by register
  //   bits 4..0  voltage code
  //
  // Read path
  //   Read data is a flop that follows the address one cycle later. This
  //   keeps the port output glitch free at the cost of one cycle of latency.
  //   Unmapped offsets read as zero and take no write.
  //
  // Voltage targets
  //   Each regulator code maps onto a millivolt target on a fixed 100 mV
  //   ladder. Codes at or above the saturation code all give the top level,
  //   so a careless host cannot push a regulator past its range.
  //   The target is computed from the next code, so a write is seen on the
  //   target in the same cycle as the code, even while the regulator is on.
  //
  // Power-on sequence
  //   A short counter holds both regulators off after reset. The delay is
  //   longer than the synchroniser, so a pin tied high is settled before the
  //   analog regulator looks at it. Both are released together; the analog one comes up only with its pin or override bit set.
  //
  // Analog enable
  //   With the override bit clear the pin decides; with it set the regulator
  //   stays on whatever the pin does. The pin passes two flops first, so the
  //   output trails a pin change by three clock edges.
  //
  // Switcher modulation
  //   A light-load flag picks pulse-frequency mode unless the register forces
  //   pulse-width mode. The flag is asynchronous and is synchronised as well.
  //
  // Limitation: the block only sets enables and targets; the analog stages
  // behind them, their ramps and their shunts, live outside this logic.

  rcr_pkg::rcr_state_t state_reg; // Whole register bank state
  rcr_pkg::rcr_state_t state_next;
  logic [2:0] pins_sync; // Settled pin and comparator levels
  logic pin_en; // Settled analog enable pin
  logic core_light; // Settled core switcher light-load flag
  logic io_light; // Settled IO switcher light-load flag

  // Map a voltage code onto a millivolt target, clamping at the saturation code
  function automatic logic [11:0] code_to_mv
  (
    input logic [4:0] code,
    input logic [11:0] base_mv,
    input logic [4:0] sat_code
  );
    logic [4:0] eff;
    logic [16:0] prod;
    eff = (code >= sat_code) ? sat_code : code;
    prod = {12'h000, eff} * {5'h00, `RCR_STEP_MV};
    code_to_mv = base_mv + prod[11:0];
  endfunction : code_to_mv

  // Read view of one control register; bits seven and six always zero
  function automatic logic [7:0] pack_ctrl
  (
    input logic ctrl,
    input logic [4:0] code
  );
    pack_ctrl = {2'h0, ctrl, code};
  endfunction : pack_ctrl

  // Pin and comparators are asynchronous, so they settle before any use
  rcr_sync u_sync
  (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .async_in({io_switcher_light_load, core_switcher_light_load, analog_regulator_enable_pin}),
    .sync_out(pins_sync)
  );

  assign pin_en = pins_sync[0];
  assign core_light = pins_sync[1];
  assign io_light = pins_sync[2];

  // Next-state logic: register writes, read mux, power-on sequence and outputs
  always_comb
  begin
    state_next = state_reg;
    // Writes land at once, even while the regulator is on
    if (reg_wr)
    begin
      unique case (reg_addr)
        `RCR_GEN_CTRL_OFS:
        begin
          state_next.gen_code = reg_wdata[`RCR_CODE_MSB:`RCR_CODE_LSB];
          state_next.gen_en = reg_wdata[`RCR_CTRL_BIT];
        end
        `RCR_ANA_CTRL_OFS:
        begin
          state_next.ana_code = reg_wdata[`RCR_CODE_MSB:`RCR_CODE_LSB];
          state_next.ana_force = reg_wdata[`RCR_CTRL_BIT];
        end
        `RCR_CORE_CTRL_OFS:
        begin
          state_next.core_code = reg_wdata[`RCR_CODE_MSB:`RCR_CODE_LSB];
          state_next.core_fpwm = reg_wdata[`RCR_CTRL_BIT];
        end
        `RCR_IO_CTRL_OFS:
        begin
          state_next.io_code = reg_wdata[`RCR_CODE_MSB:`RCR_CODE_LSB];
          state_next.io_fpwm = reg_wdata[`RCR_CTRL_BIT];
        end
        default:
        begin
          // Unmapped offsets take no write
        end
      endcase
    end
    // Read data follows the address one cycle later; upper two bits never stored
    unique case (reg_addr)
      `RCR_GEN_CTRL_OFS: state_next.rdata = pack_ctrl(state_reg.gen_en, state_reg.gen_code);
      `RCR_ANA_CTRL_OFS: state_next.rdata = pack_ctrl(state_reg.ana_force, state_reg.ana_code);
      `RCR_CORE_CTRL_OFS: state_next.rdata = pack_ctrl(state_reg.core_fpwm, state_reg.core_code);
      `RCR_IO_CTRL_OFS: state_next.rdata = pack_ctrl(state_reg.io_fpwm, state_reg.io_code);
      default: state_next.rdata = 8'h00;
    endcase
    // Power-on delay, long enough for the pin to clear its synchroniser
    if (!state_reg.seq_done)
    begin
      if (state_reg.seq_cnt == SEQ_LAST)
      begin
        state_next.seq_done = 1'h1;
      end
      else
      begin
        state_next.seq_cnt = state_reg.seq_cnt + 4'h1;
      end
    end
    // Targets use the new code so a write takes effect with no disable step
    state_next.gen_mv = code_to_mv(state_next.gen_code, `RCR_GEN_BASE_MV, `RCR_GEN_SAT_CODE);
    state_next.ana_mv = code_to_mv(state_next.ana_code, `RCR_ANA_BASE_MV, `RCR_ANA_SAT_CODE);
    // Both regulators release together at the end of the power-on delay
    state_next.gen_on = state_next.seq_done & state_next.gen_en;
    state_next.ana_on = state_next.seq_done & (state_next.ana_force | pin_en);
    // Light load picks PFM unless PWM is forced
    state_next.core_pwm = state_next.core_fpwm | ~core_light;
    state_next.io_pwm = state_next.io_fpwm | ~io_light;
  end

  // Synchronous reset loads the power-on defaults; the host should set code before enable
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      state_reg <= '0;
      state_reg.gen_code <= `RCR_GEN_CODE_RST;
      state_reg.gen_en <= `RCR_GEN_EN_RST;
      state_reg.ana_code <= `RCR_ANA_CODE_RST;
      state_reg.ana_force <= `RCR_ANA_EN_RST;
      state_reg.core_code <= `RCR_SW_CODE_RST;
      state_reg.core_fpwm <= `RCR_SW_FPWM_RST;
      state_reg.io_code <= `RCR_SW_CODE_RST;
      state_reg.io_fpwm <= `RCR_SW_FPWM_RST;
      state_reg.gen_mv <= `RCR_GEN_BASE_MV;
      state_reg.ana_mv <= `RCR_ANA_BASE_MV;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Every output comes straight from the state flops
  assign reg_rdata = state_reg.rdata;
  assign general_regulator_en = state_reg.gen_on;
  assign general_regulator_mv = state_reg.gen_mv;
  assign analog_regulator_en = state_reg.ana_on;
  assign analog_regulator_mv = state_reg.ana_mv;
  assign core_switcher_code = state_reg.core_code;
  assign core_switcher_pwm = state_reg.core_pwm;
  assign io_switcher_code = state_reg.io_code;
  assign io_switcher_pwm = state_reg.io_pwm;

endmodule : rcr_regs

/* File: rtl/rcr_consts.svh */
// Offsets, field positions, reset values and timing counts of the regulator control registers
`ifndef RCR_CONSTS_SVH
`define RCR_CONSTS_SVH

// Register offsets on the serial register port
`define RCR_GEN_CTRL_OFS 8'h08
`define RCR_ANA_CTRL_OFS 8'h09
`define RCR_CORE_CTRL_OFS 8'h05
`define RCR_IO_CTRL_OFS 8'h06

// Field positions shared by all four control registers
`define RCR_CODE_MSB 4
`define RCR_CODE_LSB 0
`define RCR_CTRL_BIT 5

// Reset values of the regulator fields
`define RCR_GEN_CODE_RST 5'h08
`define RCR_GEN_EN_RST 1'h1
`define RCR_ANA_CODE_RST 5'h14
`define RCR_ANA_EN_RST 1'h0
`define RCR_SW_CODE_RST 5'h00
`define RCR_SW_FPWM_RST 1'h0

// Voltage ladders, in millivolts, and the code at which each saturates
`define RCR_STEP_MV 12'h064
`define RCR_GEN_BASE_MV 12'h4B0
`define RCR_GEN_SAT_CODE 5'h15
`define RCR_ANA_BASE_MV 12'h514
`define RCR_ANA_SAT_CODE 5'h14

// Power-on enable delay, shared by both linear regulators
`define RCR_CLK_PERIOD_NS 10
`define RCR_SEQ_DELAY_NS 100
`define RCR_SEQ_CYCLES ((`RCR_SEQ_DELAY_NS + `RCR_CLK_PERIOD_NS - 1) / `RCR_CLK_PERIOD_NS)

`endif

/* File: rtl/rcr_pkg.sv */
// Types of the regulator control register block
package rcr_pkg;

  // Whole state of the register bank
  typedef struct packed {
    logic [4:0] gen_code;  // General regulator voltage code
    logic gen_en;          // General regulator enable bit
    logic [4:0] ana_code;  // Analog regulator voltage code
    logic ana_force;       // Analog regulator override bit
    logic [4:0] core_code; // Core switcher voltage code
    logic core_fpwm;       // Core switcher force-PWM bit
    logic [4:0] io_code;   // IO switcher voltage code
    logic io_fpwm;         // IO switcher force-PWM bit
    logic [3:0] seq_cnt;   // Power-on sequencing counter
    logic seq_done;        // Power-on sequence finished
    logic [7:0] rdata;     // Registered read data
    logic [11:0] gen_mv;   // General regulator target in mV
    logic [11:0] ana_mv;   // Analog regulator target in mV
    logic gen_on;          // General regulator enable output
    logic ana_on;          // Analog regulator enable output
    logic core_pwm;        // Core switcher modulation output
    logic io_pwm;          // IO switcher modulation output
  } rcr_state_t;

  // State of the input synchroniser
  typedef struct packed {
    logic [2:0] stage1; // First flop, read only by the second
    logic [2:0] stage2; // Settled copy
  } rcr_sync_state_t;

endpackage : rcr_pkg

/* File: rtl/rcr_sync.sv */
// Two-flop synchroniser for the asynchronous pin and comparator inputs
`timescale 1ns/1ps

module rcr_sync
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [2:0] async_in,
  output logic [2:0] sync_out
);

  rcr_pkg::rcr_sync_state_t state_reg; // Both flop stages
  rcr_pkg::rcr_sync_state_t state_next;

  // Shift the pin levels through two stages
  always_comb
  begin
    state_next = state_reg;
    state_next.stage1 = async_in;
    state_next.stage2 = state_reg.stage1;
  end

  // Synchronous reset clears both stages to a known low
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign sync_out = state_reg.stage2;

endmodule : rcr_sync

/* File: test/rcr_regs_asserts.sv */
// Port checks for the regulator control registers
`timescale 1ns/1ps
module rcr_regs_chk
(
  input logic core_clk,
  input logic rst_b,
  input logic [7:0] reg_addr,
  input logic reg_wr,
  input logic [7:0] reg_wdata,
  input logic [7:0] reg_rdata,
  input logic analog_regulator_enable_pin,
  input logic core_switcher_light_load,
  input logic general_regulator_en,
  input logic [11:0] general_regulator_mv,
  input logic analog_regulator_en,
  input logic [11:0] analog_regulator_mv,
  input logic core_switcher_pwm
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);
  // Target in mV; the ladder stops at 3300
  function automatic logic [11:0] lvl(input logic [4:0] c, input logic [4:0] s, input logic [11:0] b);
    return (c >= s) ? 12'hCE4 : b + 12'h064 * c;
  endfunction : lvl
  // Pin left in charge, general regulator up, pin steady while it settles
  sequence s_pin_mode;
    reg_wr && reg_addr == 8'h09 && !reg_wdata[5] && general_regulator_en
    ##1 (!reg_wr && $stable(analog_regulator_enable_pin))[*4];
  endsequence
  // Core switcher written, light load steady
  sequence s_core_mode;
    reg_wr && reg_addr == 8'h05 ##1 (!reg_wr && $stable(core_switcher_light_load))[*4];
  endsequence
  a_gen_level: assert property (
    reg_wr && reg_addr == 8'h08 |=> general_regulator_mv == lvl($past(reg_wdata[4:0]), 5'h15, 12'h4B0))
    else $error("general level");
  a_ana_level: assert property (
    reg_wr && reg_addr == 8'h09 |=> analog_regulator_mv == lvl($past(reg_wdata[4:0]), 5'h14, 12'h514))
    else $error("analog level");
  a_ana_force: assert property (
    reg_wr && reg_addr == 8'h09 && reg_wdata[5] && general_regulator_en |=> analog_regulator_en)
    else $error("analog override");
  a_ana_pin: assert property (s_pin_mode |-> analog_regulator_en == analog_regulator_enable_pin)
    else $error("analog pin");
  a_read_back: assert property (
    reg_wr && reg_addr[7:1] == 7'h04 ##1 !reg_wr && $stable(reg_addr) |=> reg_rdata == {2'b00, $past(reg_wdata[5:0], 2)})
    else $error("read back");
  a_gen_boot: assert property ($rose(rst_b) |-> !general_regulator_en [*8] ##[2:4] general_regulator_en)
    else $error("general boot");
  a_ana_boot: assert property (
    $rose(rst_b) |-> ##4 (analog_regulator_en == (general_regulator_en && analog_regulator_enable_pin)) [*8])
    else $error("analog boot");
  a_core_mode: assert property (
    s_core_mode |-> core_switcher_pwm == ($past(reg_wdata[5], 4) || !core_switcher_light_load))
    else $error("core mode");
endmodule : rcr_regs_chk
bind rcr_regs rcr_regs_chk u_chk (.core_clk, .rst_b, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata,
  .analog_regulator_enable_pin, .core_switcher_light_load, .general_regulator_en, .general_regulator_mv,
  .analog_regulator_en, .analog_regulator_mv, .core_switcher_pwm);

/* File: test/rcr_host.sv */
// Host model driving the byte register port
`timescale 1ns/1ps
module rcr_host
(
  input logic core_clk,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr
);
  // Idle port at time zero
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
  end
  // One strobe across one rising edge; address stays for readback
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
    reg_wdata = ~d; // Released data stops showing the byte
  endtask : wr
  // Level first, then enable, so the output never starts at a stale level
  task automatic turn_on(input logic [7:0] a, input logic [4:0] c);
    wr(a, {3'b000, c});
    wr(a, {3'b001, c});
  endtask : turn_on
endmodule : rcr_host

/* File: test/test_rcr_regs.sv */
// Self-checking bench of the regulator control registers
`timescale 1ns/1ps
module test_rcr_regs;
  logic core_clk, rst_b, reg_wr, analog_regulator_enable_pin, core_switcher_light_load, io_switcher_light_load;
  logic general_regulator_en, analog_regulator_en, core_switcher_pwm, io_switcher_pwm;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic [4:0] core_switcher_code, io_switcher_code, cc = 5'h00, ic = 5'h00; // Outputs and their expected values
  logic [11:0] general_regulator_mv, analog_regulator_mv;
  logic [15:0] rnd = 16'h4948; // Seed 18760
  logic [14:0] q[$]; // Notes: output select and expected value
  logic look = 1'b0; // A note waits for the next rising edge
  int n_mismatch = 0;
  int n_compared = 0;
  int cyc = 0;
  wire logic [7:0][11:0] outs = {1'b0, io_switcher_code, 1'b0, core_switcher_code,
    11'h000, io_switcher_pwm, 11'h000, core_switcher_pwm, 11'h000, analog_regulator_en,
    11'h000, general_regulator_en, analog_regulator_mv, general_regulator_mv, 4'h0, reg_rdata};
  rcr_host host (.core_clk, .reg_addr, .reg_wdata, .reg_wr);
  rcr_regs dut (.core_clk, .rst_b, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .analog_regulator_enable_pin,
    .core_switcher_light_load, .io_switcher_light_load, .general_regulator_en, .general_regulator_mv,
    .analog_regulator_en, .analog_regulator_mv, .core_switcher_code, .core_switcher_pwm, .io_switcher_code,
    .io_switcher_pwm);
  // 100 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [11:0] mv(input logic [4:0] c, input logic [4:0] s, input logic [11:0] b);
    return (c >= s) ? 12'hCE4 : b + 12'h064 * c;
  endfunction : mv
  task automatic check(input logic [11:0] seen, input logic [11:0] want);
    n_compared++;
    if (seen !== want)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %h not %h", $time, seen, want);
    end
  endtask : check
  task automatic end_sim;
    $display("%0d mismatches, %0d compares", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim
  task automatic note(input logic [2:0] s, input logic [11:0] v);
    @(negedge core_clk);
    q.push_back({s, v});
    look = 1'b1;
  endtask : note
  // Pin held across reset so the synchroniser is flushed
  task automatic boot(input logic p);
    rst_b = 1'b0;
    analog_regulator_enable_pin = p;
    repeat (3) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (13) @(negedge core_clk);
  endtask : boot
  // Compares before the edge's own updates land; also cuts a hang short
  always @(posedge core_clk)
  begin
    cyc++;
    if (look)
    begin
      look = 1'b0;
      check(outs[q[0][14:12]], q[0][11:0]);
      void'(q.pop_front());
    end
    if (cyc == 2000)
    begin
      n_mismatch++;
      end_sim();
    end
  end
  initial
  begin
    core_switcher_light_load = 1'b0;
    io_switcher_light_load = 1'b0;
    boot(1'b1);
    note(3'h3, 12'h001);
    note(3'h4, 12'h001);
    note(3'h1, 12'h7D0);
    host.turn_on(8'h08, 5'h0A);
    note(3'h1, 12'h898);
    // Analog half first, while the general regulator is surely on
    for (int i = 0; i < 64; i++)
    begin
      rnd = lfsr(rnd);
      d = {rnd[7:5], i[4:0]};
      analog_regulator_enable_pin = rnd[8];
      host.wr(i[5] ? 8'h08 : 8'h09, d);
      repeat (3) @(negedge core_clk);
      note(3'h0, {6'h00, d[5:0]});
      note(i[5] ? 3'h1 : 3'h2, i[5] ? mv(d[4:0], 5'h15, 12'h4B0) : mv(d[4:0], 5'h14, 12'h514));
      note(i[5] ? 3'h3 : 3'h4, {11'h000, d[5] | (!i[5] & analog_regulator_enable_pin)});
    end
    for (int j = 0; j < 8; j++)
    begin
      core_switcher_light_load = j[0];
      io_switcher_light_load = j[0];
      rnd = lfsr(rnd);
      if (j[2])
        ic = rnd[4:0];
      else
        cc = rnd[4:0];
      host.wr(j[2] ? 8'h06 : 8'h05, {2'b00, j[1], rnd[4:0]});
      repeat (3) @(negedge core_clk);
      note(j[2] ? 3'h6 : 3'h5, {11'h000, j[1] | !j[0]});
      note(3'h7, {1'b0, ic, 1'b0, cc});
    end
    host.wr(8'h33, 8'hFF);
    note(3'h0, 12'h000);
    boot(1'b0);
    note(3'h4, 12'h000);
    note(3'h3, 12'h001);
    note(3'h2, 12'hCE4);
    end_sim();
  end
endmodule : test_rcr_regs
